// [inc/nvc_pkg.sv]
// Functional notes
// - host holds address stable through the write
// - host keeps output enable high during writes
// - host pulls busy pin low to request store
// - host releases busy pin; accesses blocked until it reads high and recovery ends
// - six ordered reads with strobe high start store
`default_nettype none
package nvc_pkg;
  // ------------------------------------------------------------
  // widths and timing
  // ------------------------------------------------------------
  localparam int ADDR_W = 18;
  localparam int DATA_W = 16;
  localparam int SEQ_LAST = 5;
  localparam int CLK_FREQ_MHZ = 40;
  localparam int RD_ACCESS_NS = 50;
  localparam int WR_PULSE_NS = 50;
  localparam int STORE_START_DELAY_NS = 100;
  localparam int POST_STORE_RECOVERY_NS = 100;

  function automatic int ns_to_cyc(input int ns);
    int c;
    c = (ns * CLK_FREQ_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int RD_CYC = ns_to_cyc(RD_ACCESS_NS);
  localparam int WR_CYC = ns_to_cyc(WR_PULSE_NS);
  localparam int START_CYC = ns_to_cyc(STORE_START_DELAY_NS);
  localparam int RECOVERY_CYC = ns_to_cyc(POST_STORE_RECOVERY_NS);
  localparam logic [7:0] RD_LOAD = 8'(RD_CYC - 1);
  localparam logic [7:0] WR_LOAD = 8'(WR_CYC - 1);
  localparam logic [7:0] START_LOAD = 8'(START_CYC - 1);
  localparam logic [7:0] RECOVERY_LOAD = 8'(RECOVERY_CYC - 1);
  localparam logic [7:0] SETTLE_LOAD = 8'h00;

  // ------------------------------------------------------------
  // types
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    NVC_CMD_READ = 2'h0,
    NVC_CMD_WRITE = 2'h1,
    NVC_CMD_HW_STORE = 2'h2,
    NVC_CMD_SW_STORE = 2'h3
  } nvc_cmd_e;

  typedef enum logic [7:0] {
    ST_IDLE = 8'h01,
    ST_RD = 8'h02,
    ST_WR_SETUP = 8'h04,
    ST_WR = 8'h08,
    ST_END = 8'h10,
    ST_HS_PULL = 8'h20,
    ST_HS_WAIT = 8'h40,
    ST_RECOVER = 8'h80
  } nvc_state_e;

  typedef struct packed {
    nvc_cmd_e cmd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [1:0] be_n;
  } nvc_req_s;

  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic upper_byte_en_n;
    logic lower_byte_en_n;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dq_o;
    logic dq_oe_n;
    logic store_busy_n_o;
    logic store_busy_n_oe_n;
  } nvc_pins_s;

  typedef struct packed {
    logic rvalid;
    logic done;
    logic [DATA_W-1:0] rdata;
  } nvc_rsp_s;

  localparam nvc_pins_s PINS_IDLE = '{
    ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, upper_byte_en_n: 1'b1,
    lower_byte_en_n: 1'b1, addr: 18'h0_0000, dq_o: 16'h0000, dq_oe_n: 1'b1,
    store_busy_n_o: 1'b0, store_busy_n_oe_n: 1'b1};
  localparam nvc_rsp_s RSP_IDLE = '{rvalid: 1'b0, done: 1'b0, rdata: 16'h0000};

  function automatic logic [ADDR_W-1:0] seq_addr(input logic [2:0] i);
    logic [15:0] a;
    case (i)
      3'h0: a = 16'h4e38;
      3'h1: a = 16'hb1c7;
      3'h2: a = 16'h83e0;
      3'h3: a = 16'h7c1f;
      3'h4: a = 16'h703f;
      default: a = 16'h8fc0;
    endcase
    return {2'h0, a};
  endfunction
endpackage
`default_nettype wire

// [logic/nvc_host.sv]
`default_nettype none
module nvc_host
  import nvc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic req_valid,
  input wire nvc_req_s req,
  output var logic req_ready,
  output var nvc_rsp_s rsp,
  output var nvc_pins_s pins,
  input wire logic [DATA_W-1:0] dq_i,
  input wire logic store_busy_n_i
);
  typedef struct packed {
    nvc_state_e state;
    nvc_pins_s pins;
    logic req_ready;
    nvc_rsp_s rsp;
    logic [2:0] idx;
    logic sw;
    logic store_cmd;
  } nvc_host_st_s;

  localparam nvc_host_st_s ST_RST = '{
    state: ST_IDLE, pins: PINS_IDLE, req_ready: 1'b0, rsp: RSP_IDLE,
    idx: 3'h0, sw: 1'b0, store_cmd: 1'b0};

  nvc_host_st_s st_reg;
  nvc_host_st_s st_next;
  logic tmr_load;
  logic [7:0] tmr_val;
  logic tmr_zero;
  logic accept;

  nvc_timer u_timer (
    .clk_sys(clk_sys),
    .arst_n(arst_n),
    .clk_en(clk_en),
    .load(tmr_load),
    .load_val(tmr_val),
    .expired(tmr_zero)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rsp.rvalid = 1'b0;
    st_next.rsp.done = 1'b0;
    tmr_load = 1'b0;
    tmr_val = 8'h00;
    accept = req_valid && st_reg.req_ready && store_busy_n_i;
    case (st_reg.state)
      ST_IDLE: begin
        st_next.pins = PINS_IDLE;
        st_next.req_ready = store_busy_n_i && !accept;
        if (!store_busy_n_i) begin
          st_next.state = ST_HS_WAIT;
          st_next.store_cmd = 1'b0;
          tmr_load = 1'b1;
          tmr_val = SETTLE_LOAD;
        end else if (accept) begin
          st_next.store_cmd = 1'b0;
          st_next.sw = 1'b0;
          st_next.pins.addr = req.addr;
          st_next.pins.upper_byte_en_n = req.be_n[1];
          st_next.pins.lower_byte_en_n = req.be_n[0];
          case (req.cmd)
            NVC_CMD_READ: begin
              st_next.pins.ce_n = 1'b0;
              st_next.pins.oe_n = 1'b0;
              st_next.state = ST_RD;
              tmr_load = 1'b1;
              tmr_val = RD_LOAD;
            end
            NVC_CMD_WRITE: begin
              st_next.pins.ce_n = 1'b0;
              st_next.pins.dq_o = req.wdata;
              st_next.pins.dq_oe_n = 1'b0;
              st_next.state = ST_WR_SETUP;
            end
            NVC_CMD_HW_STORE: begin
              st_next.pins.store_busy_n_oe_n = 1'b0;
              st_next.store_cmd = 1'b1;
              st_next.state = ST_HS_PULL;
              tmr_load = 1'b1;
              tmr_val = START_LOAD;
            end
            default: begin
              st_next.sw = 1'b1;
              st_next.store_cmd = 1'b1;
              st_next.idx = 3'h0;
              st_next.pins.addr = seq_addr(3'h0);
              st_next.pins.upper_byte_en_n = 1'b0;
              st_next.pins.lower_byte_en_n = 1'b0;
              st_next.pins.ce_n = 1'b0;
              st_next.pins.oe_n = 1'b0;
              st_next.state = ST_RD;
              tmr_load = 1'b1;
              tmr_val = RD_LOAD;
            end
          endcase
        end
      end
      ST_RD: begin
        if (tmr_zero) begin
          st_next.rsp.rdata = dq_i;
          st_next.rsp.rvalid = !st_reg.sw;
          st_next.pins.ce_n = 1'b1;
          st_next.pins.oe_n = 1'b1;
          st_next.state = ST_END;
        end
      end
      ST_WR_SETUP: begin
        st_next.pins.we_n = 1'b0;
        st_next.state = ST_WR;
        tmr_load = 1'b1;
        tmr_val = WR_LOAD;
      end
      ST_WR: begin
        if (tmr_zero) begin
          st_next.pins.we_n = 1'b1;
          st_next.pins.ce_n = 1'b1;
          st_next.state = ST_END;
        end
      end
      ST_END: begin
        st_next.pins.dq_oe_n = 1'b1;
        st_next.pins.upper_byte_en_n = 1'b1;
        st_next.pins.lower_byte_en_n = 1'b1;
        if (st_reg.sw && st_reg.idx != 3'(SEQ_LAST) && !store_busy_n_i) begin
          // device went busy mid sequence: give up
          st_next.sw = 1'b0;
          st_next.store_cmd = 1'b0;
          st_next.state = ST_HS_WAIT;
          tmr_load = 1'b1;
          tmr_val = SETTLE_LOAD;
        end else if (st_reg.sw && st_reg.idx != 3'(SEQ_LAST)) begin
          st_next.idx = st_reg.idx + 3'h1;
          st_next.pins.addr = seq_addr(st_reg.idx + 3'h1);
          st_next.pins.upper_byte_en_n = 1'b0;
          st_next.pins.lower_byte_en_n = 1'b0;
          st_next.pins.ce_n = 1'b0;
          st_next.pins.oe_n = 1'b0;
          st_next.state = ST_RD;
          tmr_load = 1'b1;
          tmr_val = RD_LOAD;
        end else if (st_reg.sw) begin
          // sixth read done: device may already be busy
          st_next.sw = 1'b0;
          st_next.state = ST_HS_WAIT;
          tmr_load = 1'b1;
          tmr_val = START_LOAD;
        end else begin
          st_next.rsp.done = 1'b1;
          st_next.req_ready = store_busy_n_i;
          st_next.state = ST_IDLE;
        end
      end
      ST_HS_PULL: begin
        if (tmr_zero) begin
          st_next.pins.store_busy_n_oe_n = 1'b1;
          st_next.state = ST_HS_WAIT;
          tmr_load = 1'b1;
          tmr_val = SETTLE_LOAD;
        end
      end
      ST_HS_WAIT: begin
        if (tmr_zero && store_busy_n_i) begin
          st_next.state = ST_RECOVER;
          tmr_load = 1'b1;
          tmr_val = RECOVERY_LOAD;
        end
      end
      ST_RECOVER: begin
        if (!store_busy_n_i) begin
          st_next.state = ST_HS_WAIT;
          tmr_load = 1'b1;
          tmr_val = SETTLE_LOAD;
        end else if (tmr_zero) begin
          st_next.rsp.done = st_reg.store_cmd;
          st_next.store_cmd = 1'b0;
          st_next.req_ready = 1'b1;
          st_next.state = ST_IDLE;
        end
      end
      default: begin
        st_next = ST_RST;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= ST_RST;
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign req_ready = st_reg.req_ready;
  assign rsp = st_reg.rsp;
  assign pins = st_reg.pins;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  localparam int start_cyc_c = START_CYC;

  default clocking cb @(posedge clk_sys iff clk_en);
  endclocking
  default disable iff (!arst_n);

  property p_addr_hold;
    (!pins.we_n || $rose(pins.we_n)) |-> $stable(pins.addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved during write");

  property p_data_setup;
    $fell(pins.we_n) |-> !pins.dq_oe_n && !pins.ce_n && !$past(pins.ce_n);
  endproperty
  a_data_setup: assert property (p_data_setup) else $error("write strobe without setup");

  property p_oe_off_write;
    !pins.we_n |-> pins.oe_n;
  endproperty
  a_oe_off_write: assert property (p_oe_off_write) else $error("output enable low in write");

  property p_pull_len;
    $fell(pins.store_busy_n_oe_n) |-> ##start_cyc_c $rose(pins.store_busy_n_oe_n);
  endproperty
  a_pull_len: assert property (p_pull_len) else $error("busy pull length wrong");

  property p_no_access_busy;
    $fell(pins.ce_n) |-> $past(store_busy_n_i) && pins.store_busy_n_oe_n;
  endproperty
  a_no_access_busy: assert property (p_no_access_busy) else $error("access while busy low");

  property p_wait_release;
    (st_reg.state == ST_HS_WAIT) |-> pins.store_busy_n_oe_n && pins.ce_n && pins.we_n;
  endproperty
  a_wait_release: assert property (p_wait_release) else $error("pin held while waiting");

  property p_sw_we_high;
    st_reg.sw |-> pins.we_n && pins.dq_oe_n;
  endproperty
  a_sw_we_high: assert property (p_sw_we_high) else $error("strobe low in sequence");

  property p_sw_sixth;
    (st_reg.state == ST_END && st_reg.sw && st_reg.idx == 3'h5)
      |=> st_reg.state == ST_HS_WAIT && !st_reg.sw;
  endproperty
  a_sw_sixth: assert property (p_sw_sixth) else $error("sequence did not end");

  c_read: cover property (rsp.rvalid);
  c_write_done: cover property ($rose(pins.we_n) ##[1:3] rsp.done);
  c_hw_store: cover property ($fell(pins.store_busy_n_oe_n) ##[1:300] rsp.done);
  c_sw_store: cover property (st_reg.sw && st_reg.idx == 3'h5 ##[1:300] rsp.done);
endmodule
`default_nettype wire

// [logic/nvc_timer.sv]
`default_nettype none
module nvc_timer
  import nvc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic clk_en,
  input wire logic load,
  input wire logic [7:0] load_val,
  output var logic expired
);
  typedef struct packed {
    logic [7:0] cnt;
    logic zero;
  } nvc_tmr_st_s;

  nvc_tmr_st_s st_reg;
  nvc_tmr_st_s st_next;

  always_comb begin
    st_next = st_reg;
    if (load) begin
      st_next.cnt = load_val;
    end else if (st_reg.cnt != 8'h00) begin
      st_next.cnt = st_reg.cnt - 8'h01;
    end
    st_next.zero = (st_next.cnt == 8'h00);
  end

  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      st_reg <= '{cnt: 8'h00, zero: 1'b1};
    end else if (clk_en) begin
      st_reg <= st_next;
    end
  end

  assign expired = st_reg.zero;
endmodule
`default_nettype wire

// [testbench/nvc_dev_model.sv]
`default_nettype none
module nvc_dev_model
  import nvc_pkg::*;
#(
  parameter int STORE_CYC = 20
)(
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire nvc_pins_s pins,
  input wire logic [DATA_W-1:0] dq_wire,
  input wire logic busy_wire,
  input wire logic pwr_fail,
  output var logic [DATA_W-1:0] dev_dq,
  output var logic dev_dq_en,
  output var logic dev_busy_low,
  output var logic [7:0] stores
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] SEQ [6] = '{16'h4e38, 16'hb1c7, 16'h83e0, 16'h7c1f, 16'h703f, 16'h8fc0};
  logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];
  logic pend, ce_q, sel, seq_hit;
  int cnt, rec, seq;
  // ----------------------------------------
  // access gating and read drive
  // ----------------------------------------
  // selected and free
  assign sel = !pins.ce_n && busy_wire && !dev_busy_low && rec == 0;
  assign seq_hit = seq < 6 && pins.addr[15:0] == SEQ[seq];
  always_comb begin
    dev_dq_en = sel && !pins.oe_n && pins.we_n;
    dev_dq = mem[pins.addr];
    if (pins.upper_byte_en_n) dev_dq[15:8] = ~dev_dq[15:8];
    if (pins.lower_byte_en_n) dev_dq[7:0] = ~dev_dq[7:0];
  end
  // ----------------------------------------
  // writes and stores
  // ----------------------------------------
  always_ff @(posedge clk_sys or negedge arst_n) begin
    if (!arst_n) begin
      pend <= 1'b0;
      ce_q <= 1'b1;
      cnt <= 0;
      rec <= 0;
      seq <= 0;
      stores <= 8'h00;
      dev_busy_low <= 1'b0;
    end else begin
      ce_q <= pins.ce_n;
      if (rec > 0) rec <= rec - 1;
      if (sel && !pins.we_n) begin
        if (!pins.upper_byte_en_n) mem[pins.addr][15:8] <= dq_wire[15:8];
        if (!pins.lower_byte_en_n) mem[pins.addr][7:0] <= dq_wire[7:0];
        pend <= 1'b1;
        seq <= 0;
      end
      if (sel && !pins.oe_n && pins.we_n && ce_q) seq <= seq_hit ? seq + 1 : 0;
      if (cnt > 0) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          dev_busy_low <= 1'b0;
          pend <= 1'b0;
          rec <= RECOVERY_CYC;
          stores <= stores + 8'h01;
        end
      end else if ((pend && (!busy_wire || pwr_fail)) || seq == 6) begin
        dev_busy_low <= 1'b1;
        cnt <= STORE_CYC;
        seq <= 0;
      end
    end
  end
endmodule
`default_nettype wire

// [testbench/nvsram_access_and_store_control_tb_top.sv]
`default_nettype none
module nvsram_access_and_store_control_tb_top
  import nvc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int STORE_T = 20;
  logic clk_sys = 1'b0;
  logic arst_n = 1'b0;
  logic req_valid = 1'b0;
  logic pwr_fail = 1'b0;
  logic clk_en = 1'b1;
  nvc_req_s req = '0;
  logic req_ready, dev_dq_en, dev_busy_low, busy_wire;
  nvc_rsp_s rsp;
  nvc_pins_s pins;
  logic [DATA_W-1:0] dq_i, dev_dq, rd;
  logic [DATA_W-1:0] dq_last = 16'h0000;
  logic [7:0] stores;
  int cyc;
  int miscompares = 0;
  int tests_run = 0;
  // ----------------------------------------
  // clock, wires, instances
  // ----------------------------------------
  always #12.5 clk_sys = ~clk_sys;
  assign busy_wire = (pins.store_busy_n_oe_n || pins.store_busy_n_o) && !dev_busy_low;
  // undriven bus shows a toggling pattern
  assign dq_i = dev_dq_en ? dev_dq : (!pins.dq_oe_n ? pins.dq_o : ~dq_last);
  always @(posedge clk_sys) dq_last <= dq_i;
  nvc_host dut (.clk_sys(clk_sys), .arst_n(arst_n), .clk_en(clk_en), .req_valid(req_valid),
    .req(req), .req_ready(req_ready), .rsp(rsp), .pins(pins), .dq_i(dq_i),
    .store_busy_n_i(busy_wire));
  nvc_dev_model #(.STORE_CYC(STORE_T)) dev (.clk_sys(clk_sys), .arst_n(arst_n), .pins(pins),
    .dq_wire(dq_i), .busy_wire(busy_wire), .pwr_fail(pwr_fail), .dev_dq(dev_dq),
    .dev_dq_en(dev_dq_en), .dev_busy_low(dev_busy_low), .stores(stores));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic cmd(input nvc_cmd_e c, input logic [17:0] a, input logic [15:0] d,
                     input logic [1:0] b);
    int n;
    n = 0;
    @(negedge clk_sys);
    req = '{cmd: c, addr: a, wdata: d, be_n: b};
    req_valid = 1'b1;
    while (!(req_ready === 1'b1 && busy_wire === 1'b1) && n < 500) begin
      @(negedge clk_sys);
      n++;
    end
    @(negedge clk_sys);
    req_valid = 1'b0;
    cyc = 1;
    while (rsp.done !== 1'b1 && cyc < 500) begin
      @(negedge clk_sys);
      cyc++;
      if (rsp.rvalid === 1'b1) rd = rsp.rdata;
    end
    chk(32'(n < 500 && cyc < 500), 32'h1, "handshake bound");
  endtask
  task automatic tally_and_finish;
    $display("tests_run=%0d miscompares=%0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rw;
    cmd(NVC_CMD_WRITE, 18'h3_ffff, 16'h1234, 2'b00);
    chk(32'(cyc), 32'(WR_CYC + 3), "write length");
    cmd(NVC_CMD_WRITE, 18'h3_ffff, 16'hab99, 2'b01);
    cmd(NVC_CMD_WRITE, 18'h0_0001, 16'hc35a, 2'b00);
    cmd(NVC_CMD_READ, 18'h0_0001, 16'h0000, 2'b00);
    chk(32'(rd), 32'h0000_c35a, "read word");
    chk(32'(cyc), 32'(RD_CYC + 2), "read length");
    cmd(NVC_CMD_READ, 18'h3_ffff, 16'h0000, 2'b00);
    chk(32'(rd), 32'h0000_ab34, "upper byte only write");
    $display("test rw done");
  endtask
  task automatic t_stall;
    fork
      cmd(NVC_CMD_READ, 18'h0_0001, 16'h0000, 2'b00);
      begin
        repeat (2) @(negedge clk_sys);
        clk_en = 1'b0;
        repeat (3) @(negedge clk_sys);
        clk_en = 1'b1;
      end
    join
    chk(32'(cyc), 32'(RD_CYC + 5), "read length with stall");
    chk(32'(rd), 32'h0000_c35a, "read word after stall");
    $display("test stall done");
  endtask
  task automatic t_pin_store;
    cmd(NVC_CMD_HW_STORE, 18'h0_0000, 16'h0000, 2'b11);
    chk(32'(stores), 32'h1, "pin store with pending write");
    chk(32'(cyc > STORE_T), 32'h1, "waited for device busy");
    cmd(NVC_CMD_HW_STORE, 18'h0_0000, 16'h0000, 2'b11);
    chk(32'(stores), 32'h1, "pin store skipped");
    chk(32'(cyc < STORE_T), 32'h1, "no device busy");
    cmd(NVC_CMD_READ, 18'h0_0001, 16'h0000, 2'b00);
    chk(32'(rd), 32'h0000_c35a, "read after store");
    $display("test pin store done");
  endtask
  task automatic t_sw_store;
    cmd(NVC_CMD_SW_STORE, 18'h0_0000, 16'h0000, 2'b00);
    chk(32'(stores), 32'h2, "sequence store without write");
    $display("test sequence store done");
  endtask
  task automatic t_pwr_loss;
    cmd(NVC_CMD_WRITE, 18'h0_0002, 16'h0f0f, 2'b00);
    @(negedge clk_sys);
    pwr_fail = 1'b1;
    @(negedge clk_sys);
    pwr_fail = 1'b0;
    repeat (2) @(negedge clk_sys);
    chk(32'(req_ready), 32'h0, "refused while storing");
    cmd(NVC_CMD_READ, 18'h0_0002, 16'h0000, 2'b00);
    chk(32'(stores), 32'h3, "power loss store");
    chk(32'(rd), 32'h0000_0f0f, "read after power loss store");
    $display("test power loss done");
  endtask
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    @(negedge clk_sys);
    arst_n = 1'b1;
    t_rw;
    t_stall;
    t_pin_store;
    t_sw_store;
    t_pwr_loss;
    tally_and_finish;
  end
  initial begin
    #100000;
    miscompares++;
    $display("[ERR] %0t watchdog expired", $time);
    tally_and_finish;
  end
endmodule
`default_nettype wire
